/* tmw_write_port.sv */
// Texture memory write port: decodes host writes into the texture window and
// emits one memory write with per-lane enables per accepted host word.
// Assumes host writes arrive as one-cycle strobes on the engine clock and the
// memory side accepts one write per cycle.
//
// How it works
// - Texture window is write only; reads return zero, meaningless data.
// - Window starts 8 Mbyte above the memory base and spans 8 Mbyte.
// - Levels stored as a full chain, largest first, contiguous after.
// - Base value marks level zero start, counted in 8-byte units.
// - Lookups limited between lowest and highest level settings; writes are not limited here, only flagged on o_lod_in_range.
// - Base plus level offset wraps modulo the address width.
// - 16-bit level sizes in 8-byte units, quarter per level, aspect halves.
// - 8-bit levels take half the space of 16-bit levels.
// - Each write stores two 16-bit or four 8-bit texels.
// - 16-bit: low half even S, high half odd S; 1-wide drops upper.
// - 8-bit: lane n holds S low bits n; narrow maps drop upper lanes.
// - Normal layout: unit, level, T, S bits 7:1 from address.
// - Normal layout with 8-bit texels forces S bit 1 to zero.
// - Small maps right-aligned: S at bit 2, T at bit 9.
// - Sequential 8-bit layout: bit 8 zero, S bits 7:2 at bits 7:2.
// - Writes complete in arrival order, one cycle after acceptance.
module tmw_write_port
    import tmw_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Host write and read strobes, address, data and memory base
    input wire logic i_host_write,
    input wire logic i_host_read,
    input wire logic [31:0] i_host_addr,
    input wire logic [31:0] i_host_data,
    input wire logic [31:0] i_memory_base_config,
    // Texture settings
    input wire logic i_eight_bit,
    input wire logic [1:0] i_aspect,
    input wire logic i_s_dimension_wider,
    input wire logic i_seq_download,
    input wire logic [TMW_ADDR_W-1:0] i_tex_base,
    input wire logic [3:0] i_lod_min,
    input wire logic [3:0] i_lod_max,
    // Memory write side
    output logic o_mem_write,
    output logic [1:0] o_mem_unit,
    output logic [TMW_ADDR_W-1:0] o_mem_addr,
    output logic o_mem_half,
    output logic [3:0] o_mem_lanes,
    output logic [31:0] o_mem_data,
    // Host read answer and level window check
    output logic o_host_read_valid,
    output logic [31:0] o_host_read_data,
    output logic o_lod_in_range
);

    // ------------------------------------------------------------
    // Window decode
    // ------------------------------------------------------------
    wire logic [31:0] window_base;
    wire logic [31:0] window_rel;
    wire logic in_window;
    wire logic aligned;
    wire logic take_write;
    assign window_base = i_memory_base_config + TMW_WINDOW_OFFSET;
    assign window_rel = i_host_addr - window_base;
    assign in_window = (i_host_addr >= window_base) && (window_rel < TMW_WINDOW_SIZE);
    assign aligned = (i_host_addr[1:0] == 2'h0);
    assign take_write = i_host_write && in_window && aligned;

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    wire logic seq_mode;
    wire logic [1:0] unit_sel;
    wire logic [3:0] lod_sel;
    wire logic [7:0] t_coord;
    wire logic [7:0] s_coord;
    assign seq_mode = i_seq_download && i_eight_bit;
    assign unit_sel = window_rel[TMW_UNIT_LSB+1:TMW_UNIT_LSB];
    assign lod_sel = window_rel[TMW_LOD_LSB+3:TMW_LOD_LSB];
    assign t_coord = window_rel[TMW_T_LSB+7:TMW_T_LSB];
    // Normal layout places S[7:1] at 8:2; sequential places S[7:2] at 7:2
    assign s_coord = seq_mode ? {window_rel[TMW_S_LSB+5:TMW_S_LSB], 2'h0}
                   : i_eight_bit ? {window_rel[TMW_S_LSB+6:TMW_S_LSB+1], 2'h0}
                   : {window_rel[TMW_S_LSB+6:TMW_S_LSB], 1'b0};

    // ------------------------------------------------------------
    // Map width at the addressed level
    // ------------------------------------------------------------
    // Log2 of S width: 8 at level zero when S is wider, less aspect if not
    wire logic [3:0] s_log2_full;
    wire logic [3:0] s_log2;
    assign s_log2_full = i_s_dimension_wider ? 4'h8 : 4'(4'h8 - {2'h0, i_aspect});
    assign s_log2 = (lod_sel >= s_log2_full) ? 4'h0 : 4'(s_log2_full - lod_sel);

    // ------------------------------------------------------------
    // Lane enables
    // ------------------------------------------------------------
    wire logic [3:0] lanes;
    assign lanes = i_eight_bit ? ((s_log2 == 4'h0) ? 4'h1
                                : (s_log2 == 4'h1) ? 4'h3 : 4'hF)
                 : ((s_log2 == 4'h0) ? 4'h3 : 4'hF);

    // ------------------------------------------------------------
    // Address within the texture
    // ------------------------------------------------------------
    // Row pitch in half units and position of this word inside the level
    wire logic [TMW_ADDR_W:0] level_off_half;
    wire logic [TMW_ADDR_W:0] row_word;
    wire logic [TMW_ADDR_W:0] in_level_half;
    wire logic [TMW_ADDR_W:0] total_half;
    wire logic [TMW_ADDR_W:0] s_word;
    wire logic [TMW_ADDR_W:0] row_half;

    tmw_level_offset u_level_offset (
        .i_lod(lod_sel),
        .i_aspect(i_aspect),
        .i_eight_bit(i_eight_bit),
        .o_offset_half(level_off_half)
    );

    // Bytes per row are width times texel size; one unit is 8 bytes, a half is 4
    assign s_word = (TMW_ADDR_W + 1)'(s_coord >> (i_eight_bit ? 2 : 1));
    assign row_word = i_eight_bit ? ((TMW_ADDR_W + 1)'(1) << (s_log2 > 4'h1 ? s_log2 - 4'h2 : 4'h0))
                    : ((TMW_ADDR_W + 1)'(1) << (s_log2 > 4'h0 ? s_log2 - 4'h1 : 4'h0));
    assign row_half = (TMW_ADDR_W + 1)'(t_coord) * row_word;
    assign in_level_half = row_half + s_word;
    assign total_half = level_off_half + in_level_half;

    // Base and offset sum wraps at the address width
    wire logic [TMW_ADDR_W-1:0] addr_unit;
    assign addr_unit = TMW_ADDR_W'(i_tex_base + total_half[TMW_ADDR_W:1]);

    // Level limit check
    wire logic lod_ok;
    assign lod_ok = (lod_sel >= i_lod_min) && (lod_sel <= i_lod_max);

    // ------------------------------------------------------------
    // Write output registers
    // ------------------------------------------------------------
    // One memory write per accepted host word, settings sampled now
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_mem_write <= 1'b0;
            o_mem_unit <= 2'h0;
            o_mem_addr <= TMW_ADDR_RESET;
            o_mem_half <= 1'b0;
            o_mem_lanes <= TMW_LANES_RESET;
            o_mem_data <= TMW_DATA_RESET;
            o_lod_in_range <= 1'b0;
        end else begin
            o_mem_write <= take_write;
            if (take_write) begin
                o_mem_unit <= unit_sel;
                o_mem_addr <= addr_unit;
                o_mem_half <= total_half[0];
                o_mem_lanes <= lanes;
                o_mem_data <= i_host_data;
                o_lod_in_range <= lod_ok;
            end
        end
    end

    // ------------------------------------------------------------
    // Host read answer
    // ------------------------------------------------------------
    // Reads of the window are answered with zero, no storage looked up
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_host_read_valid <= 1'b0;
            o_host_read_data <= TMW_DATA_RESET;
        end else begin
            o_host_read_valid <= i_host_read && in_window;
            o_host_read_data <= TMW_DATA_RESET;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    write_follows_a: assert property (@(posedge i_clock) disable iff (i_reset)
        take_write |=> o_mem_write) else $error("accepted write not issued");
    outside_drop_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_host_write && !in_window) |=> !o_mem_write) else $error("write outside window issued");
    misaligned_drop_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_host_write && !aligned) |=> !o_mem_write) else $error("misaligned write issued");
    data_pass_a: assert property (@(posedge i_clock) disable iff (i_reset)
        take_write |=> o_mem_data == $past(i_host_data)) else $error("write data altered");
    wide16_lanes_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (take_write && !i_eight_bit && s_log2 == 4'h0) |=> o_mem_lanes == 4'h3) else $error("1-wide 16-bit lanes");
    narrow8_lanes_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (take_write && i_eight_bit && s_log2 == 4'h1) |=> o_mem_lanes == 4'h3) else $error("2-wide 8-bit lanes");
    one8_lanes_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (take_write && i_eight_bit && s_log2 == 4'h0) |=> o_mem_lanes == 4'h1) else $error("1-wide 8-bit lanes");
    unit_field_a: assert property (@(posedge i_clock) disable iff (i_reset)
        take_write |=> o_mem_unit == $past(window_rel[22:21])) else $error("unit select wrong");
    seq_s_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (take_write && seq_mode) |-> s_word == (TMW_ADDR_W + 1)'(window_rel[TMW_S_LSB+5:TMW_S_LSB]))
        else $error("sequential S position wrong");
    norm8_s_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (take_write && i_eight_bit && !i_seq_download) |-> s_word == (TMW_ADDR_W + 1)'(window_rel[8:3]))
        else $error("8-bit S position wrong");
    read_zero_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_host_read && in_window) |=> o_host_read_valid && o_host_read_data == 32'h0) else $error("read answer");

endmodule : tmw_write_port

/* tmw_pkg.sv */
// Package for the texture memory write port: constants shared by the port
// and its level-offset helper.
// Assumes a single engine clock; no register bus, settings arrive as ports.
package tmw_pkg;

    // ------------------------------------------------------------
    // Address window
    // ------------------------------------------------------------
    localparam logic [31:0] TMW_WINDOW_OFFSET = 32'h0080_0000; // 8 Mbyte above base
    localparam logic [31:0] TMW_WINDOW_SIZE = 32'h0080_0000;   // 8 Mbyte span

    // ------------------------------------------------------------
    // Address field positions
    // ------------------------------------------------------------
    localparam int TMW_UNIT_LSB = 21;
    localparam int TMW_LOD_LSB = 17;
    localparam int TMW_T_LSB = 9;
    localparam int TMW_S_LSB = 2;
    localparam int TMW_SEQ_ZERO_BIT = 8;

    // ------------------------------------------------------------
    // Sizes and widths
    // ------------------------------------------------------------
    localparam int TMW_ADDR_W = 20;              // Memory address, 8-byte units
    localparam int TMW_LOD_LEVELS = 9;
    localparam int TMW_LEVEL0_LOG2 = 14;          // Square level zero, 16-bit texels
    localparam int TMW_UNIT_BYTES = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [TMW_ADDR_W-1:0] TMW_ADDR_RESET = 20'h0_0000;
    localparam logic [3:0] TMW_LANES_RESET = 4'h0;
    localparam logic [31:0] TMW_DATA_RESET = 32'h0000_0000;

    // Texel width selector
    typedef enum logic {
        TMW_TEXEL_16,
        TMW_TEXEL_8
    } tmw_texel_type;

endpackage : tmw_pkg

/* tmw_level_offset.sv */
// Level offset helper: half-unit offset of a level from level zero.
// Assumes settings stay stable while the offset is consumed (combinational).
module tmw_level_offset
    import tmw_pkg::*;
(
    // Level and map shape
    input wire logic [3:0] i_lod,
    input wire logic [1:0] i_aspect,
    input wire logic i_eight_bit,
    // Offset in half units of 8 bytes
    output logic [TMW_ADDR_W:0] o_offset_half
);

    // ------------------------------------------------------------
    // Size helper
    // ------------------------------------------------------------
    // Size of one 16-bit level in units, floored at one unit
    // Narrow side never shrinks below two texels, so aspect stops halving there
    function automatic logic [TMW_ADDR_W:0] tmw_level_size(input int lod, input logic [1:0] aspect);
        int sh;
        int narrow;
        narrow = (int'(aspect) < TMW_LOD_LEVELS - 2 - lod) ? int'(aspect) : TMW_LOD_LEVELS - 2 - lod;
        sh = TMW_LEVEL0_LOG2 - 2 * lod - narrow;
        if (sh < 0) begin
            sh = 0;
        end
        return (TMW_ADDR_W + 1)'(1) << sh;
    endfunction : tmw_level_size

    // ------------------------------------------------------------
    // Offset sum
    // ------------------------------------------------------------
    // Sum of all larger levels; 8-bit halves the size in half units
    always_comb begin
        o_offset_half = '0;
        for (int l = 0; l < TMW_LOD_LEVELS; l++) begin
            if (l < int'(i_lod)) begin
                if (i_eight_bit) begin
                    o_offset_half = o_offset_half + tmw_level_size(l, i_aspect);
                end else begin
                    o_offset_half = o_offset_half + (tmw_level_size(l, i_aspect) << 1);
                end
            end
        end
    end

endmodule : tmw_level_offset

/* tmw_host_model.sv */
// Host model: issues memory write and read strobes to the port, held until the next put.
// Assumes the caller invokes put just after a falling clock edge.
module tmw_host_model (
    // Requests toward the write port
    output logic o_write,
    output logic o_read,
    output logic [31:0] o_addr,
    output logic [31:0] o_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // Quiet bus at time zero
    initial begin
        o_write = 1'b0;
        o_read = 1'b0;
        o_addr = 32'h0000_0000;
        o_data = 32'h0000_0000;
    end

    // Kind 1 write, 2 read, 0 idle; an idle bus shows inverted values
    task automatic put(input int kind, input logic [31:0] addr, input logic [31:0] data);
        o_write = (kind == 1);
        o_read = (kind == 2);
        o_addr = (kind == 0) ? ~o_addr : addr;
        o_data = (kind == 0) ? ~o_data : data;
    endtask : put
endmodule : tmw_host_model

/* tb_top.sv */
// Testbench: random host traffic in and around the texture window, checked each cycle.
// Assumes registered outputs one cycle after each request.
module tb_top import tmw_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_clock, i_reset, host_write, host_read, i_eight_bit, i_s_dimension_wider, i_seq_download;
    logic [31:0] host_addr, host_data, i_memory_base_config;
    logic [1:0] i_aspect, o_mem_unit;
    logic [TMW_ADDR_W-1:0] i_tex_base, o_mem_addr;
    logic [3:0] i_lod_min, i_lod_max, o_mem_lanes;
    logic o_mem_write, o_mem_half, o_host_read_valid, o_lod_in_range;
    logic [31:0] o_mem_data, o_host_read_data;
    int failures = 0;
    int checks = 0;

    tmw_host_model i_host (.o_write(host_write), .o_read(host_read), .o_addr(host_addr), .o_data(host_data));
    tmw_write_port i_dut (.i_clock(i_clock), .i_reset(i_reset), .i_host_write(host_write),
        .i_host_read(host_read), .i_host_addr(host_addr), .i_host_data(host_data),
        .i_memory_base_config(i_memory_base_config), .i_eight_bit(i_eight_bit), .i_aspect(i_aspect),
        .i_s_dimension_wider(i_s_dimension_wider), .i_seq_download(i_seq_download),
        .i_tex_base(i_tex_base), .i_lod_min(i_lod_min), .i_lod_max(i_lod_max),
        .o_mem_write(o_mem_write), .o_mem_unit(o_mem_unit), .o_mem_addr(o_mem_addr),
        .o_mem_half(o_mem_half), .o_mem_lanes(o_mem_lanes), .o_mem_data(o_mem_data),
        .o_host_read_valid(o_host_read_valid), .o_host_read_data(o_host_read_data),
        .o_lod_in_range(o_lod_in_range));

    // Pseudo-random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
        checks++;
        if (seen !== expected) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, expected, seen);
        end
    endtask : check

    // Counts, verdict and end of run
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // 100 MHz clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // Reference model: request held over the edge gives this cycle's answer
    always @(posedge i_clock) begin : monitor
        logic [31:0] off;
        logic win;
        logic wr;
        int lod, half, wl, lanes, sh;
        #2;
        off = host_addr - i_memory_base_config - 32'h0080_0000;
        win = (off < 32'h0080_0000);
        wr = host_write && win && (host_addr[1:0] == 2'h0);
        if (!i_reset) begin
            check("write pulse", o_mem_write, wr);
            check("read answer", o_host_read_valid, host_read && win);
            if (host_read && win) check("read data", o_host_read_data, 32'h0000_0000);
            if (wr) begin
                lod = off[20:17];
                half = 0;
                // Level sizes in half units: narrow side at least two texels, at least one unit for 16-bit, one half for 8-bit
                for (int l = 0; l < lod && l < TMW_LOD_LEVELS; l++) begin
                    sh = 14 - 2 * l - ((int'(i_aspect) < 7 - l) ? int'(i_aspect) : 7 - l);
                    half += (2 >> i_eight_bit) << (sh < 0 ? 0 : sh);
                end
                wl = 8 - lod - (i_s_dimension_wider ? 0 : int'(i_aspect));
                if (wl < 0) wl = 0;
                lanes = i_eight_bit ? (wl == 0 ? 1 : (wl == 1 ? 3 : 15)) : (wl == 0 ? 3 : 15);
                // Row pitch in halves from the S width, then the S word inside the row
                sh = wl - 1 - int'(i_eight_bit);
                half += int'(off[16:9]) << (sh < 0 ? 0 : sh);
                half += i_eight_bit ? (i_seq_download ? int'(off[7:2]) : int'(off[8:3])) : int'(off[8:2]);
                check("unit", o_mem_unit, off[22:21]);
                check("address", o_mem_addr, (i_tex_base + (half >> 1)) & 32'h000F_FFFF);
                check("half", o_mem_half, half & 1);
                check("lanes", o_mem_lanes, lanes);
                check("data", o_mem_data, host_data);
                check("in range", o_lod_in_range, i_lod_min <= lod && lod <= i_lod_max);
            end
        end
    end

    // Stimulus: reset, then back-to-back random requests with fresh settings
    initial begin : stimulus
        logic [31:0] r, d, a;
        int kind;
        r = 32'h0000_6FF1;
        i_reset = 1'b1;
        {i_eight_bit, i_aspect, i_s_dimension_wider, i_seq_download} = 5'h00;
        {i_memory_base_config, i_tex_base, i_lod_min, i_lod_max} = 60'h0;
        repeat (4) @(negedge i_clock);
        i_reset = 1'b0;
        for (int n = 0; n < 800; n++) begin
            @(negedge i_clock);
            r = lfsr_next(r);
            d = lfsr_next(r);
            r = lfsr_next(d);
            {i_eight_bit, i_aspect, i_s_dimension_wider, i_seq_download} = r[13:9];
            {i_lod_min, i_lod_max} = d[7:0];
            i_tex_base = r[27:8];
            i_memory_base_config = {d[31:24], 24'h00_0000};
            a = i_memory_base_config + 32'h0080_0000 + {r[22:21], 4'(r[3:0] % 9), d[30:16], 2'h0};
            kind = r[31:28];
            case (kind)
                10: a = a | 32'h0000_0001;
                11: a = i_memory_base_config + 32'h007F_FFFC;
                12: a = i_memory_base_config + 32'h0100_0000;
                14: a = i_memory_base_config;
                default: a = a;
            endcase
            i_host.put(kind < 13 ? 1 : (kind < 15 ? 2 : 0), a, d);
        end
        repeat (2) @(negedge i_clock);
        give_verdict();
    end

    // Watchdog against a hang
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
endmodule : tb_top
